// *** dds_pkg.sv ***
// shared widths, limits and carrier types for the phase/amplitude core
package dds_pkg;
  localparam int ACC_W = 32;
  localparam int PHS_W = 16;
  localparam int AMP_W = 12;
  localparam int DAC_W = 12;
  localparam int SRC_N = 4;
  // index of each parameter source, highest precedence first
  localparam int SRC_MODULUS = 0;
  localparam int SRC_RAMP = 1;
  localparam int SRC_PROFILE = 2;
  localparam int SRC_PARALLEL = 3;
  // parameter refresh interval in sample clocks
  localparam logic [4:0] MOD_DIV = 5'h18;
  localparam logic [4:0] MOD_LAST = 5'h17;
  // calibration length in sample clock periods
  localparam int CAL_CYCLES = 469632;
  localparam logic [ACC_W-1:0] ACC_RST = 32'h0000_0000;
  localparam logic [PHS_W-1:0] QTR_TURN = 16'h4000;
  localparam logic [PHS_W-1:0] HALF_TURN = 16'h8000;
  localparam logic [DAC_W-2:0] MAG_PEAK = 11'h7FF;
  localparam int MAG_LSB = 17;
  localparam int SCALE_LSB = 12;

  typedef struct packed {
    logic [ACC_W-1:0] freq;
    logic [PHS_W-1:0] phase;
    logic [AMP_W-1:0] amp;
  } dds_param_t;

  typedef struct packed {
    logic freq;
    logic phase;
    logic amp;
  } dds_en_t;

  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_ARMED,
    CAL_RUN
  } dds_cal_state_t;
endpackage : dds_pkg

// *** dds_core.sv ***
// phase accumulator, angle-to-amplitude, scaling and dac calibration timer
// Notes on behaviour
// - sine when select set, cosine when clear
// - 32-bit accumulator adds step word each sample
// - step words above half scale accumulate unchanged
// - 16-bit phase offset added before conversion
// - sample scaled by amplitude word over 4096
// - parameters applied once every 24 clocks
// - calibration runs exactly 469632 sample periods
// - one 12-bit scaled sample per clock
// - modulus, ramp, profile, parallel source precedence
`timescale 1ns/100ps
module dds_core #(
  parameter int CAL_LEN = dds_pkg::CAL_CYCLES
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // control bits
  input wire logic sine_sel_i,
  input wire logic dac_cal_en_i,
  // parameter sources, index 0 highest precedence
  input wire dds_pkg::dds_param_t [dds_pkg::SRC_N-1:0] src_param_i,
  input wire dds_pkg::dds_en_t [dds_pkg::SRC_N-1:0] src_en_i,
  // sample stream to the converter
  input wire logic dac_ready_i,
  output logic dac_valid_o,
  output logic signed [dds_pkg::DAC_W-1:0] dac_sample_o,
  // status
  output logic dac_cal_busy_o,
  output logic upd_tick_o
);

  // ---------------- parameter selection and refresh
  dds_pkg::dds_param_t sel_param;
  dds_pkg::dds_param_t act_r, act_nxt;
  logic [4:0] div_r, div_nxt;
  logic tick_r, tick_nxt;

  always_comb begin
    sel_param = act_r;
    // walk lowest to highest so the higher source overwrites
    for (int s = dds_pkg::SRC_N - 1; s >= 0; s--) begin
      if (src_en_i[s].freq) begin
        sel_param.freq = src_param_i[s].freq;
      end
      if (src_en_i[s].phase) begin
        sel_param.phase = src_param_i[s].phase;
      end
      if (src_en_i[s].amp) begin
        sel_param.amp = src_param_i[s].amp;
      end
    end
  end

  always_comb begin
    div_nxt = div_r + 5'h01;
    tick_nxt = 1'b0;
    act_nxt = act_r;
    if (div_r == dds_pkg::MOD_LAST) begin
      // images at the refresh rate are the price of a slow update path
      div_nxt = '0;
      tick_nxt = 1'b1;
      act_nxt = sel_param;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      div_r <= '0;
      tick_r <= 1'b0;
      act_r <= '0;
    end else begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
      act_r <= act_nxt;
    end
  end

  assign upd_tick_o = tick_r;

  // ---------------- accumulator and angle-to-amplitude
  logic [dds_pkg::ACC_W-1:0] acc_r, acc_nxt;
  logic [dds_pkg::PHS_W-1:0] phase;
  logic [dds_pkg::PHS_W-1:0] half_pos;
  logic [dds_pkg::PHS_W-1:0] half_cmp;
  logic [2*dds_pkg::PHS_W-1:0] parab;
  logic [dds_pkg::DAC_W-1:0] mag_raw;
  logic [dds_pkg::DAC_W-2:0] mag;
  logic signed [dds_pkg::DAC_W-1:0] wave;
  logic signed [dds_pkg::DAC_W+dds_pkg::AMP_W:0] prod;
  logic signed [dds_pkg::DAC_W-1:0] scaled;
  logic in_ready;

  always_comb begin
    // offset is added to the top of the accumulator, not accumulated
    phase = acc_r[dds_pkg::ACC_W-1 -: dds_pkg::PHS_W]
      + act_r.phase;
    if (!sine_sel_i) begin
      phase = phase + dds_pkg::QTR_TURN;
    end
    // parabolic half-wave: cheap, no table, about 5% peak error
    half_pos = {1'b0, phase[dds_pkg::PHS_W-2:0]};
    half_cmp = dds_pkg::HALF_TURN - half_pos;
    parab = half_pos * half_cmp;
    mag_raw = parab[dds_pkg::MAG_LSB +: dds_pkg::DAC_W];
    mag = mag_raw[dds_pkg::DAC_W-1] ? dds_pkg::MAG_PEAK
      : mag_raw[dds_pkg::DAC_W-2:0];
    wave = phase[dds_pkg::PHS_W-1] ? -$signed({1'b0, mag})
      : $signed({1'b0, mag});
    prod = wave * $signed({1'b0, act_r.amp});
    scaled = prod[dds_pkg::SCALE_LSB +: dds_pkg::DAC_W];
  end

  always_comb begin
    acc_nxt = acc_r;
    if (in_ready) begin
      // full 32-bit wrap, no clamp above half scale
      acc_nxt = acc_r + act_r.freq;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      acc_r <= dds_pkg::ACC_RST;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // ---------------- two-entry skid buffer toward the converter
  logic out_vld_r, out_vld_nxt;
  logic skid_vld_r, skid_vld_nxt;
  logic signed [dds_pkg::DAC_W-1:0] out_r, out_nxt;
  logic signed [dds_pkg::DAC_W-1:0] skid_r, skid_nxt;
  logic pop;

  // a stall backs up into the accumulator so no sample is dropped
  assign in_ready = !skid_vld_r;

  always_comb begin
    pop = out_vld_r && dac_ready_i;
    out_vld_nxt = out_vld_r;
    out_nxt = out_r;
    skid_vld_nxt = skid_vld_r;
    skid_nxt = skid_r;
    if (!out_vld_r || pop) begin
      out_vld_nxt = 1'b1;
      out_nxt = skid_vld_r ? skid_r : scaled;
      skid_vld_nxt = 1'b0;
    end else if (in_ready) begin
      skid_vld_nxt = 1'b1;
      skid_nxt = scaled;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      out_vld_r <= 1'b0;
      skid_vld_r <= 1'b0;
      out_r <= '0;
      skid_r <= '0;
    end else begin
      out_vld_r <= out_vld_nxt;
      skid_vld_r <= skid_vld_nxt;
      out_r <= out_nxt;
      skid_r <= skid_nxt;
    end
  end

  assign dac_valid_o = out_vld_r;
  assign dac_sample_o = out_r;

  // ---------------- converter timing calibration
  dds_pkg::dds_cal_state_t cal_st_r, cal_st_nxt;
  logic [19:0] cal_cnt_r, cal_cnt_nxt;
  logic cal_busy_r, cal_busy_nxt;
  localparam logic [19:0] CAL_END = 20'(CAL_LEN - 1);

  always_comb begin
    cal_st_nxt = cal_st_r;
    cal_cnt_nxt = cal_cnt_r;
    cal_busy_nxt = 1'b0;
    unique case (cal_st_r)
      dds_pkg::CAL_IDLE: begin
        if (dac_cal_en_i) begin
          cal_st_nxt = dds_pkg::CAL_ARMED;
        end
      end
      dds_pkg::CAL_ARMED: begin
        // starts on the clear that follows the set
        if (!dac_cal_en_i) begin
          cal_st_nxt = dds_pkg::CAL_RUN;
          cal_cnt_nxt = '0;
          cal_busy_nxt = 1'b1;
        end
      end
      dds_pkg::CAL_RUN: begin
        cal_busy_nxt = 1'b1;
        cal_cnt_nxt = cal_cnt_r + 20'h00001;
        if (cal_cnt_r == CAL_END) begin
          cal_st_nxt = dac_cal_en_i ? dds_pkg::CAL_ARMED
            : dds_pkg::CAL_IDLE;
          cal_busy_nxt = 1'b0;
        end
      end
      // the fourth code is unused; fall back to idle
      default: begin
        cal_st_nxt = dds_pkg::CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cal_st_r <= dds_pkg::CAL_IDLE;
      cal_cnt_r <= '0;
      cal_busy_r <= 1'b0;
    end else begin
      cal_st_r <= cal_st_nxt;
      cal_cnt_r <= cal_cnt_nxt;
      cal_busy_r <= cal_busy_nxt;
    end
  end

  assign dac_cal_busy_o = cal_busy_r;

  // ---------------- checks
  logic [20:0] busy_len_r;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      busy_len_r <= '0;
    end else begin
      busy_len_r <= cal_busy_r ? busy_len_r + 21'h000001 : '0;
    end
  end

  a_acc_step: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    in_ready |=> acc_r == $past(acc_r) + $past(act_r.freq))
    else $error("accumulator did not advance by step word");
  a_acc_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !in_ready |=> $stable(acc_r))
    else $error("accumulator moved while stalled");
  a_tick_space: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    tick_r |=> !tick_r [*8] ##16 tick_r)
    else $error("parameter refresh not every 24 clocks");
  a_param_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !tick_r |-> $stable(act_r))
    else $error("parameters changed between refresh ticks");
  a_src_prio: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (div_r == dds_pkg::MOD_LAST && src_en_i[0].freq)
    |=> act_r.freq == $past(src_param_i[0].freq))
    else $error("modulus source lost frequency precedence");
  a_cal_start: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (cal_st_r == dds_pkg::CAL_ARMED && !dac_cal_en_i)
    |=> cal_busy_r [*8])
    else $error("calibration did not start on bit clear");
  a_cal_length: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $fell(cal_busy_r) |-> $past(busy_len_r) == 21'(CAL_LEN - 1))
    else $error("calibration length wrong");
  a_zero_scale: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (act_r.amp == '0 && in_ready && (!out_vld_r || pop) && !skid_vld_r)
    |=> dac_sample_o == '0)
    else $error("zero amplitude word gave nonzero sample");
  a_stream_flow: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    dac_ready_i [*2] |=> dac_valid_o)
    else $error("no sample delivered while converter ready");
  a_cos_peak: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (!sine_sel_i && acc_r[31:16] == '0 && act_r.phase == '0)
    |-> wave == $signed({1'b0, dds_pkg::MAG_PEAK}))
    else $error("cosine select did not start at peak");

endmodule : dds_core

// *** dds_dac_sink.sv ***
// converter-side sink model that takes samples and stalls on command
`timescale 1ns/100ps
module dds_dac_sink (
  // clock, reset and commanded back-pressure
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic stall_i,
  // sample stream and what was taken
  input wire logic valid_i,
  input wire logic signed [11:0] sample_i,
  output logic ready_o,
  output logic took_o,
  output logic signed [11:0] word_o
);
  // ready moves only after an edge; a taken word is reported a cycle later
  always_ff @(posedge clk_i) begin
    ready_o <= rst_n_i & ~stall_i;
    took_o <= valid_i & ready_o;
    word_o <= sample_i;
  end
endmodule : dds_dac_sink

// *** tb_dds_phase_amplitude_core.sv ***
// self-checking bench for the phase/amplitude core
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %0t got %0d exp %0d", $time, g, e); end end
module tb_dds_phase_amplitude_core;
  logic core_clk_i = 0, rst_n_i = 0, sine_sel_i = 0, dac_cal_en_i = 0;
  logic stall = 0, stall_en = 0, dac_ready, dac_valid, busy, tick, took;
  dds_pkg::dds_param_t [3:0] src_param = '0;
  dds_pkg::dds_en_t [3:0] src_en = '0;
  logic signed [11:0] dac_sample, word;
  logic [7:0] lf = 8'h06;
  int n_fail = 0, tests_run = 0, mode = 0, want, first, p1, p2, e, gap;
  int seen, cnt;
  int amps[4] = '{4095, 2048, 3000, 1000};
  always #12.5 core_clk_i = ~core_clk_i;
  dds_core #(.CAL_LEN(20)) i_dut (.core_clk_i, .rst_n_i, .sine_sel_i,
    .dac_cal_en_i, .src_param_i(src_param), .src_en_i(src_en),
    .dac_ready_i(dac_ready), .dac_valid_o(dac_valid),
    .dac_sample_o(dac_sample), .dac_cal_busy_o(busy), .upd_tick_o(tick));
  dds_dac_sink i_sink (.clk_i(core_clk_i), .rst_n_i, .stall_i(stall),
    .valid_i(dac_valid), .sample_i(dac_sample), .ready_o(dac_ready),
    .took_o(took), .word_o(word));
  function automatic logic [7:0] lfsr(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // wave times scale over 4096, floored like an arithmetic shift
  function automatic int scl(int w, int a);
    return (w * a) >>> 12;
  endfunction : scl
  always @(posedge core_clk_i) begin
    lf <= lfsr(lf);
    stall <= stall_en & lf[0];
  end
  always @(negedge core_clk_i) begin
    if (took && mode == 1)
      `CHK(word, 12'(want))
    // quarter-turn steps give 0,+pk,0,-pk; the first peak shows direction
    if (took && mode == 2 && (seen || word != 0)) begin
      e = seen ? (p1 != 0 ? 0 : (p2 == 2046 ? -2047 : 2046)) : first;
      `CHK(word, 12'(e))
      seen = 1;
      p2 = p1;
      p1 = word;
    end
    if (!rst_n_i) gap = 0;
    else if (tick) begin
      if (gap > 0) `CHK(gap, 24)
      gap = 1;
    end else if (gap > 0) gap++;
  end
  task automatic run(logic [31:0] f, logic [15:0] ph, logic s, int lo,
                     int m, int w);
    @(posedge core_clk_i);
    rst_n_i <= 0;
    mode = 0;
    seen = 0;
    p1 = 0;
    src_param[3].freq <= f;
    src_param[3].phase <= ph;
    sine_sel_i <= s;
    for (int k = 0; k < 4; k++) src_en[k] <= {k == 3, k == 3, k >= lo};
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1;
    for (int i = 0; i < 30 && tick !== 1; i++) @(negedge core_clk_i);
    `CHK(tick, 1'b1)
    stall_en <= 1;
    want = w;
    first = w;
    if (m == 2) mode = 2;
    // let stale words drain from the skid before static checks
    repeat (24) @(negedge core_clk_i);
    mode = m;
    repeat (40) @(negedge core_clk_i);
    mode = 0;
    stall_en <= 0;
  endtask : run
  task automatic cal_start;
    @(posedge core_clk_i) dac_cal_en_i <= 1;
    @(posedge core_clk_i) dac_cal_en_i <= 0;
  endtask : cal_start
  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    for (int k = 0; k < 4; k++) src_param[k].amp = 12'(amps[k]);
    run(0, 16'h0000, 1, 3, 1, 0);
    run(0, 16'h4000, 1, 3, 1, scl(2047, 1000));
    run(0, 16'hC000, 1, 3, 1, scl(-2047, 1000));
    run(0, 16'h8000, 0, 3, 1, scl(-2047, 1000));
    for (int lo = 0; lo < 5; lo++)
      run(0, 16'h0000, 0, lo, 1, lo < 4 ? scl(2047, amps[lo]) : 0);
    run(32'h4000_0000, 16'h0000, 1, 0, 2, 2046);
    run(32'hC000_0000, 16'h0000, 1, 0, 2, -2047);
    cal_start();
    cnt = 0;
    for (int i = 0; i < 100 && (cnt == 0 || busy); i++) begin
      @(negedge core_clk_i);
      if (busy === 1) cnt++;
    end
    `CHK(cnt, 20)
    cal_start();
    repeat (5) @(posedge core_clk_i);
    rst_n_i <= 0;
    repeat (2) @(negedge core_clk_i);
    `CHK(busy, 1'b0)
    rst_n_i <= 1;
    give_verdict();
  end
  initial begin
    #(25 * 6000);
    n_fail++;
    give_verdict();
  end
endmodule : tb_dds_phase_amplitude_core
